// file: shared/sdc_cfg.svh
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH
// ==========================================
// Register map of the controller
`define SDC_OFF_CTRL 8'h00
`define SDC_OFF_ADDR 8'h04
`define SDC_OFF_WDATA 8'h08
`define SDC_OFF_RDATA 8'h0c
`define SDC_OFF_STAT 8'h10
`define SDC_OFF_MODE 8'h14
// ==========================================
// Control word fields
`define SDC_CTRL_GO 0
`define SDC_CTRL_CMD_LO 1
`define SDC_CTRL_CMD_HI 3
`define SDC_CTRL_AUTO 4
`define SDC_CTRL_LMASK 5
`define SDC_CTRL_HMASK 6
`define SDC_CTRL_REFEN 7
// ==========================================
// Status word fields
`define SDC_STAT_BUSY 0
`define SDC_STAT_INIT 1
`define SDC_STAT_BANK0 2
`define SDC_STAT_BANK1 3
`define SDC_STAT_RVALID 4
// ==========================================
// Timing, in ns and in cycles
`define SDC_CLK_NS 10
`define SDC_POWERUP_NS 100000
`define SDC_REFRESH_NS 16000000
`define SDC_REFRESH_COUNT 1024
`define SDC_MODE_SETTLE 2
`define SDC_WRITE_RECOVERY 1
`define SDC_CMD_PERIOD_CL3 9
`define SDC_ACT_TO_PRE_CL3 6
`define SDC_MODE_RESET 10'h030
`define SDC_DQ_SYNC_STAGES 3'd2
`endif

// file: shared/sdc_pkg.sv
`default_nettype none
package sdc_pkg;
	// ==========================================
	// Pin command encoding: cs_n, ras_n, cas_n, we_n
	typedef enum logic [3:0] {
		SDC_PIN_LOAD = 4'h0,
		SDC_PIN_REFRESH = 4'h1,
		SDC_PIN_PRECHARGE = 4'h2,
		SDC_PIN_ACTIVATE = 4'h3,
		SDC_PIN_WRITE = 4'h4,
		SDC_PIN_READ = 4'h5,
		SDC_PIN_STOP = 4'h6,
		SDC_PIN_NOP = 4'h7,
		SDC_PIN_DESELECT = 4'h8
	} sdc_pin_cmd_type;
	// ==========================================
	// Software orders
	typedef enum logic [2:0] {
		SDC_OP_ACTIVATE = 3'h0,
		SDC_OP_READ = 3'h1,
		SDC_OP_WRITE = 3'h2,
		SDC_OP_PRECHARGE = 3'h3,
		SDC_OP_REFRESH = 3'h4,
		SDC_OP_LOAD = 3'h5,
		SDC_OP_STOP = 3'h6,
		SDC_OP_NOP = 3'h7
	} sdc_op_type;
	// ==========================================
	// Pins toward the memory
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [9:0] addr;
		logic low_byte_mask;
		logic high_byte_mask;
	} sdc_pins_type;
	// ==========================================
	// Order passed to the sequencer
	typedef struct packed {
		sdc_op_type op;
		logic bank_select_bit;
		logic autoclose_or_all_banks_bit;
		logic [8:0] row_col;
		logic [15:0] wdata;
		logic low_byte_mask;
		logic high_byte_mask;
	} sdc_order_type;
endpackage : sdc_pkg
`default_nettype wire

// file: logic/sdc_timer.sv
`timescale 1ns/1ns
`default_nettype none
module sdc_timer #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Load and state
	input wire logic load,
	input wire logic [WIDTH-1:0] value,
	output logic done
);
	logic [WIDTH-1:0] count;
	// ==========================================
	// Down counter, done when zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count <= '0;
		end else if (load) begin
			count <= value;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end
	assign done = (count == '0) && !load;
endmodule : sdc_timer
`default_nettype wire

// file: logic/sdc_ahb_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_cfg.svh"
module sdc_ahb_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Register side
	output logic [31:0] ctrl,
	output logic ctrl_strobe,
	output logic [31:0] addr_reg,
	output logic [15:0] wdata_reg,
	output logic [9:0] mode_reg,
	input wire logic [31:0] status,
	input wire logic [15:0] rdata
);
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [7:0] off;
	assign off = haddr[7:0];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// ==========================================
	// Address phase capture
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			wr_addr <= off;
		end
	end
	// ==========================================
	// Write data phase
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl <= 32'h0;
			ctrl_strobe <= 1'b0;
			addr_reg <= 32'h0;
			wdata_reg <= 16'h0;
			mode_reg <= `SDC_MODE_RESET;
		end else begin
			ctrl_strobe <= 1'b0;
			if (wr_pend) begin
				unique case (wr_addr)
					`SDC_OFF_CTRL: begin
						ctrl <= hwdata;
						ctrl_strobe <= hwdata[`SDC_CTRL_GO];
					end
					`SDC_OFF_ADDR: addr_reg <= hwdata;
					`SDC_OFF_WDATA: wdata_reg <= hwdata[15:0];
					`SDC_OFF_MODE: mode_reg <= hwdata[9:0];
					default: ;
				endcase
			end
		end
	end
	// ==========================================
	// Read data, registered
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			hrdata <= 32'h0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (off)
				`SDC_OFF_CTRL: hrdata <= ctrl;
				`SDC_OFF_ADDR: hrdata <= addr_reg;
				`SDC_OFF_WDATA: hrdata <= {16'h0, wdata_reg};
				`SDC_OFF_RDATA: hrdata <= {16'h0, rdata};
				`SDC_OFF_STAT: hrdata <= status;
				`SDC_OFF_MODE: hrdata <= {22'h0, mode_reg};
				default: hrdata <= 32'h0;
			endcase
		end
	end
endmodule : sdc_ahb_regs
`default_nettype wire

// file: logic/sdc_host.sv
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_cfg.svh"
module sdc_host #(
	parameter int POWERUP_CYCLES = `SDC_POWERUP_NS / `SDC_CLK_NS,
	parameter int REFRESH_GAP =
		`SDC_REFRESH_NS / `SDC_CLK_NS / `SDC_REFRESH_COUNT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Memory pins
	output sdc_pkg::sdc_pins_type pins,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe
);
	import sdc_pkg::*;
	typedef enum {
		SDC_POWER, SDC_INIT_PRE, SDC_INIT_REF, SDC_INIT_LOAD,
		SDC_IDLE, SDC_WAIT
	} sdc_state_type;
	sdc_state_type state;
	logic [31:0] ctrl;
	logic ctrl_strobe;
	logic [31:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [9:0] mode_reg;
	logic [31:0] status;
	logic [15:0] rdata;
	logic rvalid;
	logic initialised;
	logic pending;
	logic [1:0] bank_open;
	logic [15:0] dq_s1;
	logic [15:0] dq_s2;
	logic [1:0] cl;
	logic [5:0] rd_pipe;
	logic [2:0] rd_tap;
	logic [31:0] pwr_cnt;
	logic [31:0] ref_cnt;
	logic ref_due;
	logic [1:0] init_refs;
	logic gap_done;
	logic gap_load;
	logic [7:0] gap_value;
	logic [1:0] act_done;
	logic [1:0] act_load;
	logic [1:0] pre_done;
	logic [1:0] pre_load;
	logic [7:0] rcd_value;
	logic [7:0] ras_value;
	sdc_order_type order;
	logic busy;
	logic col_ok;
	logic pre_ok;
	logic order_ready;

	// ==========================================
	// Latency-derived counts
	function automatic logic [7:0] by_cl(input logic [1:0] l,
		input logic [7:0] extra);
		by_cl = {6'h0, l} + extra;
	endfunction : by_cl
	assign cl = (mode_reg[6:4] == 3'h1) ? 2'd1 :
		(mode_reg[6:4] == 3'h2) ? 2'd2 : 2'd3;
	assign rcd_value = by_cl(cl, 8'h00);
	assign ras_value = (cl == 2'd3) ? 8'(`SDC_ACT_TO_PRE_CL3) :
		by_cl(cl, 8'h01);

	// ==========================================
	// Register bus
	sdc_ahb_regs u_regs (
		.ref_clk(ref_clk),
		.srst(srst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ctrl(ctrl),
		.ctrl_strobe(ctrl_strobe),
		.addr_reg(addr_reg),
		.wdata_reg(wdata_reg),
		.mode_reg(mode_reg),
		.status(status),
		.rdata(rdata)
	);
	assign busy = pending || (state != SDC_IDLE) || !gap_done ||
		(rd_pipe != 6'h00);
	assign rd_tap = {1'b0, cl} + `SDC_DQ_SYNC_STAGES;
	assign col_ok = bank_open[order.bank_select_bit] &&
		act_done[order.bank_select_bit];
	assign pre_ok = order.autoclose_or_all_banks_bit ?
		(pre_done == 2'b11) : pre_done[order.bank_select_bit];
	assign order_ready = gap_done && !ref_due &&
		(order.op != SDC_OP_PRECHARGE || pre_ok);
	always_comb begin
		status = 32'h0;
		status[`SDC_STAT_BUSY] = busy;
		status[`SDC_STAT_INIT] = initialised;
		status[`SDC_STAT_BANK0] = bank_open[0];
		status[`SDC_STAT_BANK1] = bank_open[1];
		status[`SDC_STAT_RVALID] = rvalid;
	end
	always_comb begin
		order.op = sdc_op_type'(ctrl[`SDC_CTRL_CMD_HI:`SDC_CTRL_CMD_LO]);
		order.bank_select_bit = addr_reg[9];
		order.autoclose_or_all_banks_bit = ctrl[`SDC_CTRL_AUTO];
		order.row_col = addr_reg[8:0];
		order.wdata = wdata_reg;
		order.low_byte_mask = ctrl[`SDC_CTRL_LMASK];
		order.high_byte_mask = ctrl[`SDC_CTRL_HMASK];
	end

	// ==========================================
	// Timers
	sdc_timer #(.WIDTH(8)) u_gap (
		.ref_clk(ref_clk), .srst(srst), .load(gap_load),
		.value(gap_value), .done(gap_done));
	for (genvar b = 0; b < 2; b++) begin : g_bank
		sdc_timer #(.WIDTH(8)) u_act (
			.ref_clk(ref_clk), .srst(srst), .load(act_load[b]),
			.value(rcd_value), .done(act_done[b]));
		sdc_timer #(.WIDTH(8)) u_pre (
			.ref_clk(ref_clk), .srst(srst), .load(pre_load[b]),
			.value(ras_value), .done(pre_done[b]));
	end

	// ==========================================
	// Input synchroniser
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dq_s1 <= 16'h0;
			dq_s2 <= 16'h0;
		end else begin
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
		end
	end

	// ==========================================
	// Power-up and refresh timing
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pwr_cnt <= 32'h0;
			ref_cnt <= 32'h0;
			ref_due <= 1'b0;
		end else begin
			if (pwr_cnt < 32'(POWERUP_CYCLES)) begin
				pwr_cnt <= pwr_cnt + 32'h1;
			end
			if (ref_cnt >= 32'(REFRESH_GAP - 1)) begin
				ref_cnt <= 32'h0;
				ref_due <= 1'b1;
			end else begin
				ref_cnt <= ref_cnt + 32'h1;
				if (state == SDC_WAIT && pins.ras_n == 1'b0 &&
					pins.cas_n == 1'b0 && pins.we_n == 1'b1)
					ref_due <= 1'b0;
			end
		end
	end

	// ==========================================
	// Order pending flag
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pending <= 1'b0;
		end else if (ctrl_strobe) begin
			pending <= 1'b1;
		end else if (state == SDC_IDLE && order_ready) begin
			pending <= 1'b0;
		end
	end

	// ==========================================
	// Read data capture
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_pipe <= 4'h0;
			rdata <= 16'h0;
			rvalid <= 1'b0;
		end else begin
			rd_pipe <= {rd_pipe[4:0], 1'b0};
			if (state == SDC_IDLE && pending && order_ready && col_ok &&
				order.op == SDC_OP_READ)
				rd_pipe[0] <= 1'b1;
			if (rd_pipe[rd_tap]) begin
				rdata <= dq_s2;
				rvalid <= 1'b1;
			end else if (ctrl_strobe) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Command sequencer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= SDC_POWER;
			pins <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
				we_n: 1'b1, addr: 10'h0, low_byte_mask: 1'b1,
				high_byte_mask: 1'b1};
			dq_out <= 16'h0;
			dq_oe <= 1'b0;
			bank_open <= 2'b00;
			initialised <= 1'b0;
			init_refs <= 2'd0;
			gap_load <= 1'b0;
			gap_value <= 8'h0;
			act_load <= 2'b00;
			pre_load <= 2'b00;
		end else begin
			{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
				SDC_PIN_NOP;
			dq_oe <= 1'b0;
			gap_load <= 1'b0;
			act_load <= 2'b00;
			pre_load <= 2'b00;
			state <= SDC_WAIT;
			unique case (state)
				SDC_POWER: begin
					state <= SDC_POWER;
					pins.cs_n <= 1'b1;
					if (pwr_cnt >= 32'(POWERUP_CYCLES)) begin
						pins.cke <= 1'b1;
						state <= SDC_INIT_PRE;
					end
				end
				SDC_INIT_PRE: begin
					{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
						SDC_PIN_PRECHARGE;
					pins.addr <= 10'h100;
					gap_value <= 8'(`SDC_CMD_PERIOD_CL3);
					gap_load <= 1'b1;
					state <= SDC_INIT_REF;
				end
				SDC_INIT_REF: begin
					state <= SDC_INIT_REF;
					if (gap_done && !gap_load) begin
						{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
							SDC_PIN_REFRESH;
						gap_value <= 8'(`SDC_CMD_PERIOD_CL3);
						gap_load <= 1'b1;
						init_refs <= init_refs + 2'd1;
						if (init_refs == 2'd1)
							state <= SDC_INIT_LOAD;
					end
				end
				SDC_INIT_LOAD: begin
					state <= SDC_INIT_LOAD;
					if (gap_done && !gap_load) begin
						{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
							SDC_PIN_LOAD;
						pins.addr <= mode_reg;
						gap_value <= 8'(`SDC_MODE_SETTLE);
						gap_load <= 1'b1;
						initialised <= 1'b1;
						state <= SDC_WAIT;
					end
				end
				SDC_WAIT: begin
					state <= SDC_IDLE;
				end
				SDC_IDLE: begin
					state <= SDC_IDLE;
					if (gap_done && ref_due && bank_open != 2'b00 &&
						pre_done == 2'b11) begin
						{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
							SDC_PIN_PRECHARGE;
						pins.addr <= 10'h100;
						bank_open <= 2'b00;
						gap_value <= by_cl(cl, 8'h00);
						gap_load <= 1'b1;
						state <= SDC_WAIT;
					end else if (gap_done && ref_due && bank_open == 2'b00) begin
						{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
							SDC_PIN_REFRESH;
						gap_value <= 8'(`SDC_CMD_PERIOD_CL3);
						gap_load <= 1'b1;
						state <= SDC_WAIT;
					end else if (order_ready && pending) begin
						state <= SDC_WAIT;
						pins.low_byte_mask <= order.low_byte_mask;
						pins.high_byte_mask <= order.high_byte_mask;
						pins.addr <= {order.bank_select_bit,
							order.row_col};
						unique case (order.op)
							SDC_OP_ACTIVATE: begin
								{pins.cs_n, pins.ras_n, pins.cas_n,
									pins.we_n} <= SDC_PIN_ACTIVATE;
								bank_open[order.bank_select_bit] <= 1'b1;
								act_load[order.bank_select_bit] <= 1'b1;
								pre_load[order.bank_select_bit] <= 1'b1;
								gap_value <= by_cl(cl, 8'h00);
								gap_load <= 1'b1;
							end
							SDC_OP_READ, SDC_OP_WRITE: begin
								if (bank_open[order.bank_select_bit] &&
									act_done[order.bank_select_bit]) begin
									{pins.cs_n, pins.ras_n, pins.cas_n,
										pins.we_n} <= (order.op ==
										SDC_OP_READ) ? SDC_PIN_READ :
										SDC_PIN_WRITE;
									pins.addr[8] <=
										order.autoclose_or_all_banks_bit;
									if (order.op == SDC_OP_WRITE) begin
										dq_out <= order.wdata;
										dq_oe <= 1'b1;
									end
									if (order.autoclose_or_all_banks_bit)
										bank_open[order.bank_select_bit]
											<= 1'b0;
									gap_value <= (order.op == SDC_OP_WRITE)
										? (order.autoclose_or_all_banks_bit
										? by_cl(cl, 8'h01)
										: 8'(`SDC_WRITE_RECOVERY))
										: 8'h00;
									gap_load <= 1'b1;
								end
							end
							SDC_OP_PRECHARGE: begin
								{pins.cs_n, pins.ras_n, pins.cas_n,
									pins.we_n} <= SDC_PIN_PRECHARGE;
								pins.addr[8] <=
									order.autoclose_or_all_banks_bit;
								if (order.autoclose_or_all_banks_bit)
									bank_open <= 2'b00;
								else
									bank_open[order.bank_select_bit] <= 1'b0;
								gap_value <= by_cl(cl, 8'h00);
								gap_load <= 1'b1;
							end
							SDC_OP_REFRESH: begin
								if (bank_open == 2'b00) begin
									{pins.cs_n, pins.ras_n, pins.cas_n,
										pins.we_n} <= SDC_PIN_REFRESH;
									gap_value <= 8'(`SDC_CMD_PERIOD_CL3);
									gap_load <= 1'b1;
								end
							end
							SDC_OP_LOAD: begin
								if (bank_open == 2'b00) begin
									{pins.cs_n, pins.ras_n, pins.cas_n,
										pins.we_n} <= SDC_PIN_LOAD;
									pins.addr <= mode_reg;
									gap_value <= 8'(`SDC_MODE_SETTLE);
									gap_load <= 1'b1;
								end
							end
							SDC_OP_STOP: begin
								{pins.cs_n, pins.ras_n, pins.cas_n,
									pins.we_n} <= SDC_PIN_STOP;
							end
							SDC_OP_NOP: ;
						endcase
					end
				end
			endcase
		end
	end

	// ==========================================
	// Checks
	mode_settle_a: assert property (@(posedge ref_clk) disable iff (srst)
		(state == SDC_WAIT && {pins.cs_n, pins.ras_n, pins.cas_n,
		pins.we_n} == SDC_PIN_LOAD) |=> ({pins.cs_n, pins.ras_n,
		pins.cas_n, pins.we_n} == SDC_PIN_NOP)[*2])
		else $error("command within mode settle time");
	refresh_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
		({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} ==
		SDC_PIN_REFRESH) |-> bank_open == 2'b00)
		else $error("refresh with open bank");
	powerup_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
		(pwr_cnt < 32'(POWERUP_CYCLES)) |-> pins.cke == 1'b0 &&
		pins.cs_n == 1'b1)
		else $error("command before power-up wait");
	refresh_gap_a: assert property (@(posedge ref_clk) disable iff (srst)
		({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} ==
		SDC_PIN_REFRESH) |=> ({pins.cs_n, pins.ras_n, pins.cas_n,
		pins.we_n} == SDC_PIN_NOP)[*8])
		else $error("command during refresh");
	write_data_a: assert property (@(posedge ref_clk) disable iff (srst)
		({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} ==
		SDC_PIN_WRITE) |-> dq_oe)
		else $error("write without data");
	column_open_a: assert property (@(posedge ref_clk) disable iff (srst)
		({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} == SDC_PIN_READ)
		|-> (pins.addr[9] ? $past(bank_open[1]) : $past(bank_open[0])))
		else $error("read to idle bank");
	act_rcd_a: assert property (@(posedge ref_clk) disable iff (srst)
		({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} ==
		SDC_PIN_ACTIVATE) |=> ({pins.cs_n, pins.ras_n, pins.cas_n,
		pins.we_n} != SDC_PIN_READ))
		else $error("column command too soon");
	load_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
		({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} == SDC_PIN_LOAD)
		|-> $past(bank_open) == 2'b00)
		else $error("mode load with open bank");
endmodule : sdc_host
`default_nettype wire

// file: dv/sdc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Two-bank memory seen from its pins
module sdc_mem_model #(
	parameter int PWR = 20
) (
	// Clock
	input wire logic ref_clk,
	// Pins from the controller
	input wire sdc_pkg::sdc_pins_type pins,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe,
	// Data back
	output logic [15:0] dq_in
);
	import sdc_pkg::*;
	logic [15:0] mem [0:511];
	logic [9:0] mode = 10'h0;
	logic [1:0] open_b = 2'b00;
	logic loaded = 1'b0;
	int refs = 0, viol = 0, cyc = 0, t_ld = -99, t_rf = -99, t_aa = -99;
	int t_act [2] = '{-99, -99};
	int t_pre [2] = '{-99, -99};
	logic [15:0] pd [4];
	logic [3:0] pv = 4'h0;
	int cl;
	logic b;
	logic [8:0] w;
	sdc_pin_cmd_type c;
	initial dq_in = 16'h0;
	// ==========================================
	// Command decode and timing watch
	always @(posedge ref_clk) begin
		cl = (mode[6:4] == 3'h1) ? 1 : (mode[6:4] == 3'h2) ? 2 : 3;
		c = sdc_pin_cmd_type'({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});
		b = pins.addr[9];
		w = {b, pins.addr[7:0]};
		pv = pv >> 1;
		for (int k = 0; k < 3; k++) pd[k] = pd[k + 1];
		if (!pins.cke || pins.cs_n || c == SDC_PIN_NOP) c = SDC_PIN_NOP;
		else if (cyc < PWR || cyc - t_ld < 2 || cyc - t_rf < 9) viol++;
		case (c)
		SDC_PIN_LOAD: begin
			if (open_b != 2'b00) viol++;
			mode = pins.addr;
			loaded = 1'b1;
			t_ld = cyc;
		end
		SDC_PIN_REFRESH: begin
			if (open_b != 2'b00) viol++;
			refs++;
			t_rf = cyc;
		end
		SDC_PIN_ACTIVATE: begin
			if (open_b[b] || cyc - t_pre[b] < 3 || cyc - t_act[b] < 9) viol++;
			if (cyc - t_aa < 3) viol++;
			open_b[b] = 1'b1;
			t_act[b] = cyc;
			t_aa = cyc;
		end
		SDC_PIN_PRECHARGE: for (int k = 0; k < 2; k++) begin
			if (pins.addr[8] || b == k[0]) begin
				if (open_b[k] && cyc - t_act[k] < 6) viol++;
				open_b[k] = 1'b0;
				t_pre[k] = cyc;
			end
		end
		SDC_PIN_READ, SDC_PIN_WRITE: begin
			if (!open_b[b] || !loaded || cyc - t_act[b] < 3) viol++;
			else if (c == SDC_PIN_READ) begin
				pv[cl] = 1'b1;
				pd[cl] = mem[w];
			end else if (!dq_oe) viol++;
			else begin
				if (!pins.low_byte_mask) mem[w][7:0] = dq_out[7:0];
				if (!pins.high_byte_mask) mem[w][15:8] = dq_out[15:8];
			end
			if (pins.addr[8]) begin
				open_b[b] = 1'b0;
				t_pre[b] = cyc + 1;
			end
		end
		// One-word bursts: stop or precharge has nothing left to cut
		SDC_PIN_STOP: ;
		default: ;
		endcase
		dq_in <= pv[1] ? pd[1] : ~dq_in;
		cyc++;
	end
endmodule : sdc_mem_model
`default_nettype wire

// file: dv/sdc_host_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_cfg.svh"
`define CHK(n, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("ERROR %s expected %h seen %h", n, e, g); \
	end \
end
module sdc_host_bench;
	import sdc_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0] htrans = 2'h0;
	logic hrdy, hresp, dq_oe;
	logic [15:0] dq_in, dq_out;
	sdc_pins_type pins;
	int failures = 0, checked = 0, r0;
	sdc_host #(.POWERUP_CYCLES(20), .REFRESH_GAP(1500)) dut_u (
		.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	sdc_mem_model #(.PWR(20)) m_u (.ref_clk(ref_clk), .pins(pins),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// ==========================================
	// Bus tasks
	task automatic stop_test;
		$display("Checks %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			stop_test();
		end
	endtask : wait_rdy
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : ahb
	task automatic op(input sdc_op_type o, input logic au,
		input logic [9:0] a, input logic [1:0] m);
		int n;
		ahb(1'b1, `SDC_OFF_ADDR, {22'h0, a});
		ahb(1'b1, `SDC_OFF_CTRL, {25'h0, m, au, o, 1'b1});
		repeat (4) @(posedge ref_clk);
		n = 0;
		do begin
			ahb(1'b0, `SDC_OFF_STAT, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 100);
		if (n >= 100) begin
			failures++;
			stop_test();
		end
	endtask : op
	task automatic banks(input logic [1:0] e);
		ahb(1'b0, `SDC_OFF_STAT, 32'h0);
		`CHK("bank state", e, q[3:2])
	endtask : banks
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		ahb(1'b0, `SDC_OFF_MODE, 32'h0);
		`CHK("mode reg", 32'h30, q)
		ahb(1'b0, 8'h18, 32'h0);
		`CHK("unmapped", 32'h0, q)
		`CHK("okay response", 1'b0, hresp)
		r0 = 0;
		do begin
			ahb(1'b0, `SDC_OFF_STAT, 32'h0);
			r0++;
		end while (!(m_u.loaded && q[0] === 1'b0) && r0 < 500);
		`CHK("init done", 1'b1, r0 < 500)
		`CHK("mode pins", 10'h030, m_u.mode)
		`CHK("init refresh", 1'b1, m_u.refs >= 2)
		op(SDC_OP_ACTIVATE, 1'b0, 10'h005, 2'b00);
		banks(2'b01);
		ahb(1'b1, `SDC_OFF_WDATA, 32'ha5c3);
		op(SDC_OP_WRITE, 1'b0, 10'h003, 2'b00);
		`CHK("write", 16'ha5c3, m_u.mem[3])
		ahb(1'b1, `SDC_OFF_WDATA, 32'h0f0f);
		op(SDC_OP_WRITE, 1'b0, 10'h003, 2'b01);
		`CHK("masked write", 16'h0fc3, m_u.mem[3])
		op(SDC_OP_READ, 1'b0, 10'h003, 2'b00);
		ahb(1'b0, `SDC_OFF_RDATA, 32'h0);
		`CHK("read", 16'h0fc3, q[15:0])
		op(SDC_OP_READ, 1'b0, 10'h203, 2'b00);
		op(SDC_OP_READ, 1'b1, 10'h003, 2'b00);
		banks(2'b00);
		op(SDC_OP_ACTIVATE, 1'b0, 10'h007, 2'b00);
		op(SDC_OP_ACTIVATE, 1'b0, 10'h207, 2'b00);
		op(SDC_OP_PRECHARGE, 1'b0, 10'h000, 2'b00);
		banks(2'b10);
		op(SDC_OP_ACTIVATE, 1'b0, 10'h007, 2'b00);
		op(SDC_OP_PRECHARGE, 1'b1, 10'h000, 2'b00);
		banks(2'b00);
		op(SDC_OP_ACTIVATE, 1'b0, 10'h211, 2'b00);
		ahb(1'b1, `SDC_OFF_WDATA, 32'h1234);
		op(SDC_OP_WRITE, 1'b1, 10'h205, 2'b00);
		banks(2'b00);
		op(SDC_OP_STOP, 1'b0, 10'h000, 2'b00);
		`CHK("bank1 write", 16'h1234, m_u.mem[9'h105])
		r0 = m_u.refs;
		op(SDC_OP_REFRESH, 1'b0, 10'h000, 2'b00);
		`CHK("refresh", r0 + 1, m_u.refs)
		r0 = m_u.refs;
		repeat (6000) @(posedge ref_clk);
		`CHK("timed refresh", 1'b1, m_u.refs - r0 >= 3)
		`CHK("pin timing", 0, m_u.viol)
		stop_test();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		stop_test();
	end
endmodule : sdc_host_bench
`default_nettype wire
